// ===== rtl/eptc_pkg.sv
// eptc_pkg: register map, field layout, reset values and timing for eptc
package eptc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ACR = 8'h04;
    localparam logic [7:0] OFS_ACR_NV = 8'h08;
    localparam logic [7:0] OFS_DIVH = 8'h0C;
    localparam logic [7:0] OFS_DIVL = 8'h10;
    localparam logic [7:0] OFS_DIVH_NV = 8'h14;
    localparam logic [7:0] OFS_DIVL_NV = 8'h18;
    localparam logic [7:0] OFS_ARRAY = 8'h1C;
    localparam logic [7:0] OFS_STAT = 8'h20;
    // array_control fields
    localparam int CTL_PGM = 0;
    localparam int CTL_LAT = 1;
    localparam int CTL_AUTO = 2;
    localparam int CTL_MODE = 3;
    localparam int CTL_SPARE = 7;
    // array_config fields
    localparam int ACR_SEC = 4;
    localparam int ACR_SPARE = 5;
    localparam logic [7:0] ACR_NV_RST = 8'hF0;
    // timebase divisor fields
    localparam int DIV_W = 11;
    localparam int DIVH_LOCK = 7;
    localparam logic [7:0] DIVH_MASK = 8'h87;
    localparam logic [7:0] DIVH_NV_RST = 8'h80;
    localparam logic [7:0] DIVL_NV_RST = 8'hAC;
    localparam logic [7:0] ERASED = 8'hFF;
    // array window: address in 15:0, data in 23:16
    localparam int ARRW_DATA = 16;
    // array and nonvolatile register addresses
    localparam logic [15:0] ARR_LO = 16'h0800;
    localparam logic [15:0] ARR_HI = 16'h09FF;
    localparam logic [15:0] SEC_LO = 16'h08F0;
    localparam logic [15:0] SEC_HI = 16'h08FF;
    localparam logic [15:0] NVA_ACR = 16'h0FE0;
    localparam logic [15:0] NVA_DIVH = 16'h0FE1;
    localparam logic [15:0] NVA_DIVL = 16'h0FE2;
    // sequence durations, counted in timebase ticks
    localparam int TICK_US = 35;
    localparam int PGM_US = 10000;
    localparam int BYTE_US = 10000;
    localparam int BLOCK_US = 10000;
    localparam int BULK_US = 10000;
    localparam int TCNT_W = 12;
    localparam logic [11:0] PGM_TICKS = 12'((PGM_US + TICK_US - 1) / TICK_US);
    localparam logic [11:0] BYTE_TICKS = 12'((BYTE_US + TICK_US - 1) / TICK_US);
    localparam logic [11:0] BLOCK_TICKS = 12'((BLOCK_US + TICK_US - 1) / TICK_US);
    localparam logic [11:0] BULK_TICKS = 12'((BULK_US + TICK_US - 1) / TICK_US);
    typedef enum logic [1:0] {
        MODE_PROG, MODE_BYTE_ERASE, MODE_BLOCK_ERASE, MODE_BULK_ERASE
    } eptc_mode_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT, SEQ_DONE} eptc_seq_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        eptc_mode_t mode;
    } eptc_cmd_t;
    typedef struct packed {
        logic wr;
        logic [7:0] ofs;
    } eptc_bus_t;
endpackage

// ===== rtl/eptc_sync.sv
// eptc_sync: two-flop synchroniser for pins from outside the bus clock
`timescale 1ns/100ps
`default_nettype none
module eptc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/eptc_timebase.sv
// eptc_timebase: divides reference clock edges into the 35 us tick
`timescale 1ns/100ps
`default_nettype none
module eptc_timebase #(
    parameter int DW = eptc_pkg::DIV_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic ref_s,
    input wire logic [DW-1:0] divisor,
    output logic tick_r
);
    logic ref_prev_r;
    logic [DW-1:0] cnt_r;
    logic rise;

    assign rise = ref_s & ~ref_prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_prev_r <= 1'b0;
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (ce) begin
            ref_prev_r <= ref_s;
            tick_r <= 1'b0;
            if (rise) begin
                // wrap at the divisor, one tick per wrap
                if (cnt_r + 1'b1 >= divisor) begin
                    cnt_r <= '0;
                    tick_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    chk_tick_on_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(ce) && tick_r |-> $past(rise) && $past(cnt_r) + 1'b1 >= $past(divisor))
        else $error("tick without a wrap of the reference count");
endmodule
`default_nettype wire

// ===== rtl/eptc_top.sv
// eptc_top: eeprom program/erase guard, array config and timebase divider
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - power on needs latch and valid write
// - clearing latch and power clears power only
// - array config reloads from nonvolatile copy
// - config bits 7:5 are plain storage
// - security bit low means security on
// - security once on never turns off
// - block protect bit locks its 128 bytes
// - secured blocks allow only byte operations
// - secured range 08F0-08FF is never written while security is on
// - nonvolatile bytes use the array sequence
// - 11-bit divisor makes the 35 us tick
// - divisor registers reload from nonvolatile bytes
// - lock low freezes divisor and its copies
// - divisor writable only unlatched and unlocked
// - programmed lock copy makes lock permanent
// - wait mode leaves the sequence running
// - stop halts and later restarts the sequence
// - power refused without latch or valid address
// - auto mode ends cycle and clears power
module eptc_top #(
    parameter logic [11:0] PGM_TICKS = eptc_pkg::PGM_TICKS,
    parameter logic [11:0] BYTE_TICKS = eptc_pkg::BYTE_TICKS,
    parameter logic [11:0] BLOCK_TICKS = eptc_pkg::BLOCK_TICKS,
    parameter logic [11:0] BULK_TICKS = eptc_pkg::BULK_TICKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic crystal_ref_clock,
    input wire logic stop_mode,
    output logic pump_on,
    output eptc_pkg::eptc_cmd_t array_cmd,
    output logic array_commit
);
    eptc_pkg::eptc_bus_t bus_r;
    eptc_pkg::eptc_cmd_t cmd_r;
    eptc_pkg::eptc_mode_t mode_r;
    eptc_pkg::eptc_seq_t seq_r;
    eptc_pkg::eptc_seq_t seq_nxt;
    logic pgm_r, lat_r, auto_r, ctl_spare_r, cmd_vld_r, restart_r;
    logic load_pend_r, tick, stop_s, ref_s, done_hit;
    logic [7:0] acr_r, acr_nv_r, divh_r, divl_r, divh_nv_r, divl_nv_r;
    logic [7:0] rd_val;
    logic [11:0] tcnt_r, need;
    logic wr_ctl, wr_acr, wr_divh, wr_divl, wr_arr, pgm_set_ok, div_wr_ok;
    logic [15:0] win_addr;
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic addr_valid(input logic [15:0] a);
        addr_valid = (a >= eptc_pkg::ARR_LO && a <= eptc_pkg::ARR_HI) ||
                     a == eptc_pkg::NVA_ACR || a == eptc_pkg::NVA_DIVH ||
                     a == eptc_pkg::NVA_DIVL;
    endfunction
    function automatic logic op_ok(input eptc_pkg::eptc_cmd_t c,
                                   input logic [7:0] acr, input logic lock_n);
        logic sec_on;
        logic [1:0] blk;
        sec_on = !acr[eptc_pkg::ACR_SEC];
        blk = c.addr[8:7];
        if (c.addr == eptc_pkg::NVA_ACR) begin
            op_ok = 1'b1;
        end else if (c.addr == eptc_pkg::NVA_DIVH || c.addr == eptc_pkg::NVA_DIVL) begin
            op_ok = lock_n;
        end else if (!addr_valid(c.addr)) begin
            op_ok = 1'b0;
        end else if (c.mode == eptc_pkg::MODE_BULK_ERASE) begin
            op_ok = !sec_on && acr[3:0] == 4'h0;
        end else if (acr[blk]) begin
            op_ok = 1'b0;
        end else if (sec_on && c.addr >= eptc_pkg::SEC_LO && c.addr <= eptc_pkg::SEC_HI) begin
            op_ok = 1'b0;
        end else begin
            op_ok = !(sec_on && c.mode == eptc_pkg::MODE_BLOCK_ERASE);
        end
    endfunction
    function automatic logic [7:0] nv_apply(input logic [7:0] old,
                                            input eptc_pkg::eptc_cmd_t c);
        nv_apply = (c.mode == eptc_pkg::MODE_PROG) ? (old & c.data) : eptc_pkg::ERASED;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and timebase
    eptc_sync #(.W(2)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .d({stop_mode, crystal_ref_clock}),
        .q({stop_s, ref_s})
    );
    eptc_timebase #(.DW(eptc_pkg::DIV_W)) u_tb (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .ref_s(ref_s),
        .divisor({divh_r[2:0], divl_r}),
        .tick_r(tick)
    );
    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    assign wr_ctl = bus_r.wr && bus_r.ofs == eptc_pkg::OFS_CTRL;
    assign wr_acr = bus_r.wr && bus_r.ofs == eptc_pkg::OFS_ACR;
    assign wr_divh = bus_r.wr && bus_r.ofs == eptc_pkg::OFS_DIVH;
    assign wr_divl = bus_r.wr && bus_r.ofs == eptc_pkg::OFS_DIVL;
    assign wr_arr = bus_r.wr && bus_r.ofs == eptc_pkg::OFS_ARRAY;
    assign win_addr = hwdata[15:0];
    assign pgm_set_ok = lat_r && cmd_vld_r && op_ok(cmd_r, acr_r, divh_r[eptc_pkg::DIVH_LOCK]);
    assign div_wr_ok = !lat_r && divh_r[eptc_pkg::DIVH_LOCK];
    always_comb begin
        case (haddr[7:0])
            eptc_pkg::OFS_CTRL: rd_val = {ctl_spare_r, 2'b00, mode_r, auto_r, lat_r, pgm_r};
            eptc_pkg::OFS_ACR: rd_val = acr_r;
            eptc_pkg::OFS_ACR_NV: rd_val = acr_nv_r;
            eptc_pkg::OFS_DIVH: rd_val = divh_r;
            eptc_pkg::OFS_DIVL: rd_val = divl_r;
            eptc_pkg::OFS_DIVH_NV: rd_val = divh_nv_r;
            eptc_pkg::OFS_DIVL_NV: rd_val = divl_nv_r;
            eptc_pkg::OFS_STAT: rd_val = {4'h0, pump_on, restart_r,
                                          seq_r == eptc_pkg::SEQ_DONE,
                                          seq_r == eptc_pkg::SEQ_RUN};
            default: rd_val = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                bus_r.wr <= hsel && htrans[1] && hwrite;
                bus_r.ofs <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    if (haddr[7:0] == eptc_pkg::OFS_ARRAY) begin
                        hrdata <= {8'h00, cmd_r.data, cmd_r.addr};
                    end else begin
                        hrdata <= {24'h00_0000, rd_val};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgm_r <= 1'b0;
            lat_r <= 1'b0;
            auto_r <= 1'b0;
            mode_r <= eptc_pkg::MODE_PROG;
            ctl_spare_r <= 1'b0;
        end else if (ce) begin
            if (wr_ctl && pgm_r) begin
                // latch stays set while power drops
                pgm_r <= hwdata[eptc_pkg::CTL_PGM];
                ctl_spare_r <= hwdata[eptc_pkg::CTL_SPARE];
            end else if (wr_ctl) begin
                lat_r <= hwdata[eptc_pkg::CTL_LAT];
                auto_r <= hwdata[eptc_pkg::CTL_AUTO];
                mode_r <= eptc_pkg::eptc_mode_t'(hwdata[eptc_pkg::CTL_MODE +: 2]);
                ctl_spare_r <= hwdata[eptc_pkg::CTL_SPARE];
                pgm_r <= hwdata[eptc_pkg::CTL_PGM] && pgm_set_ok;
            end else if (seq_r == eptc_pkg::SEQ_DONE && auto_r) begin
                pgm_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched array address and data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r <= '0;
            cmd_vld_r <= 1'b0;
        end else if (ce) begin
            if (!lat_r) begin
                cmd_vld_r <= 1'b0;
            end else if (wr_arr && !pgm_r && !restart_r && addr_valid(win_addr)) begin
                cmd_r.addr <= win_addr;
                cmd_r.data <= hwdata[eptc_pkg::ARRW_DATA +: 8];
                cmd_vld_r <= 1'b1;
            end
            if (!pgm_r) begin
                cmd_r.mode <= mode_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program/erase sequence; wait mode has no input here
    always_comb begin
        case (cmd_r.mode)
            eptc_pkg::MODE_PROG: need = PGM_TICKS;
            eptc_pkg::MODE_BYTE_ERASE: need = BYTE_TICKS;
            eptc_pkg::MODE_BLOCK_ERASE: need = BLOCK_TICKS;
            default: need = BULK_TICKS;
        endcase
    end
    assign done_hit = tick && tcnt_r + 12'h001 >= need;
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            eptc_pkg::SEQ_IDLE: begin
                if (pgm_r) begin
                    seq_nxt = eptc_pkg::SEQ_RUN;
                end
            end
            eptc_pkg::SEQ_RUN: begin
                if (stop_s && lat_r) begin
                    seq_nxt = eptc_pkg::SEQ_HALT;
                end else if (done_hit) begin
                    seq_nxt = eptc_pkg::SEQ_DONE;
                end
            end
            eptc_pkg::SEQ_HALT: begin
                if (!stop_s) begin
                    seq_nxt = eptc_pkg::SEQ_RUN;
                end
            end
            eptc_pkg::SEQ_DONE: seq_nxt = eptc_pkg::SEQ_DONE;
            default: seq_nxt = eptc_pkg::SEQ_IDLE;
        endcase
        if (!pgm_r) begin
            seq_nxt = eptc_pkg::SEQ_IDLE;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_r <= eptc_pkg::SEQ_IDLE;
            tcnt_r <= 12'h000;
            restart_r <= 1'b0;
        end else if (ce) begin
            seq_r <= seq_nxt;
            if (seq_nxt != eptc_pkg::SEQ_RUN || seq_r != eptc_pkg::SEQ_RUN) begin
                tcnt_r <= 12'h000;
            end else if (tick) begin
                tcnt_r <= tcnt_r + 12'h001;
            end
            if (seq_nxt == eptc_pkg::SEQ_HALT) begin
                restart_r <= 1'b1;
            end else if (seq_nxt == eptc_pkg::SEQ_DONE || !pgm_r) begin
                restart_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_on <= 1'b0;
            array_cmd <= '0;
            array_commit <= 1'b0;
        end else if (ce) begin
            pump_on <= pgm_r && lat_r && !stop_s &&
                       (seq_r == eptc_pkg::SEQ_RUN || seq_r == eptc_pkg::SEQ_DONE);
            array_cmd <= cmd_r;
            array_commit <= seq_r == eptc_pkg::SEQ_RUN && seq_nxt == eptc_pkg::SEQ_DONE &&
                            cmd_r.addr <= eptc_pkg::ARR_HI;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile copies, kept over system reset
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            acr_nv_r <= eptc_pkg::ACR_NV_RST;
            divh_nv_r <= eptc_pkg::DIVH_NV_RST;
            divl_nv_r <= eptc_pkg::DIVL_NV_RST;
        end else if (ce && hresetn && seq_r == eptc_pkg::SEQ_RUN
                     && seq_nxt == eptc_pkg::SEQ_DONE) begin
            // same sequence as array bytes
            if (cmd_r.addr == eptc_pkg::NVA_ACR) begin
                acr_nv_r <= nv_apply(acr_nv_r, cmd_r);
                // security never returns to off
                acr_nv_r[eptc_pkg::ACR_SEC] <= acr_nv_r[eptc_pkg::ACR_SEC] &
                    (cmd_r.mode != eptc_pkg::MODE_PROG || cmd_r.data[eptc_pkg::ACR_SEC]);
            end
            if (cmd_r.addr == eptc_pkg::NVA_DIVH) begin
                divh_nv_r <= nv_apply(divh_nv_r, cmd_r);
            end
            if (cmd_r.addr == eptc_pkg::NVA_DIVL) begin
                divl_nv_r <= nv_apply(divl_nv_r, cmd_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // live config and divisor, loaded after each reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_pend_r <= 1'b1;
            acr_r <= eptc_pkg::ACR_NV_RST;
            divh_r <= 8'h00;
            divl_r <= 8'h00;
        end else if (ce) begin
            load_pend_r <= 1'b0;
            if (load_pend_r) begin
                acr_r <= acr_nv_r;
                divh_r <= divh_nv_r & eptc_pkg::DIVH_MASK;
                divl_r <= divl_nv_r;
            end else begin
                if (wr_acr) begin
                    acr_r[7:eptc_pkg::ACR_SPARE] <= hwdata[7:eptc_pkg::ACR_SPARE];
                end
                if (wr_divh && div_wr_ok) begin
                    divh_r <= hwdata[7:0] & eptc_pkg::DIVH_MASK;
                end
                if (wr_divl && div_wr_ok) begin
                    divl_r <= hwdata[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_stop_hit;
        ce && stop_s && pgm_r && lat_r && seq_r == eptc_pkg::SEQ_RUN;
    endsequence

    sequence s_clear_both;
        ce && wr_ctl && pgm_r && !hwdata[eptc_pkg::CTL_PGM] && !hwdata[eptc_pkg::CTL_LAT];
    endsequence

    chk_pump_needs_latch: assert property (pump_on |-> $past(lat_r) && $past(pgm_r))
        else $error("pump on without latch and power");
    chk_dual_clear_keeps: assert property (s_clear_both |=> !pgm_r && lat_r)
        else $error("single write cleared the latch with power");
    chk_config_reload: assert property (ce && load_pend_r |=> acr_r == $past(acr_nv_r))
        else $error("config not reloaded after reset");
    chk_config_readonly: assert property (ce && !load_pend_r |=> acr_r[4:0] == $past(acr_r[4:0]))
        else $error("protection bits changed by software");
    chk_security_sticky: assert property (!acr_nv_r[eptc_pkg::ACR_SEC] |=> !acr_nv_r[eptc_pkg::ACR_SEC])
        else $error("security returned to disabled");
    chk_power_guard: assert property (ce && !pgm_r && wr_ctl ##1 pgm_r |-> $past(pgm_set_ok))
        else $error("power set on a refused address");
    chk_divisor_frozen: assert property (ce && !load_pend_r && !div_wr_ok |=> $stable(divh_r) && $stable(divl_r))
        else $error("divisor changed while locked or latched");
    chk_auto_clear: assert property (ce && seq_r == eptc_pkg::SEQ_DONE && auto_r && !wr_ctl |=> !pgm_r)
        else $error("auto mode did not clear power");
    chk_stop_halt: assert property (s_stop_hit |=> seq_r == eptc_pkg::SEQ_HALT ##1 !pump_on)
        else $error("stop did not halt the sequence");
endmodule
`default_nettype wire

// ===== tb/tb_eptc_top.sv
// tb_eptc_top: self-checking bench for the eeprom guard and timebase block
`timescale 1ns/100ps
`default_nettype none
module tb_eptc_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic por_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic ref_clk = 1'b0;
    logic [1:0] ref_cnt = 2'h0;
    logic stop_mode = 1'b0;
    logic ce = 1'b1;
    logic pump_on;
    eptc_pkg::eptc_cmd_t acmd;
    logic [31:0] rd;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    always #5 hclk = ~hclk;
    eptc_top #(
        .PGM_TICKS(12'h002),
        .BYTE_TICKS(12'h002),
        .BLOCK_TICKS(12'h002),
        .BULK_TICKS(12'h002)
    ) dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .por_n(por_n),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(),
        .crystal_ref_clock(ref_clk),
        .stop_mode(stop_mode),
        .pump_on(pump_on),
        .array_cmd(acmd),
        .array_commit()
    );
////////////////////////////////////////////////////////////////////////////////
    // reference clock at a quarter of the bus rate, and the hang limit
    always @(posedge hclk) begin
        ref_cnt <= ref_cnt + 2'h1;
        ref_clk <= ref_cnt[1];
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, o};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wctl(input logic [31:0] d);
        bus(1'b1, eptc_pkg::OFS_CTRL, d);
    endtask
    task automatic rdchk(input logic [7:0] o, input logic [31:0] exp, input string nm);
        bus(1'b0, o, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic reboot(input logic [31:0] acr);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdchk(eptc_pkg::OFS_ACR, acr, "acr_load");
        bus(1'b1, eptc_pkg::OFS_DIVL, 32'h10);
    endtask
    // polls until the timer drops power, then releases the latch
    task automatic wait_done(input string nm);
        for (int i = 0; i < 500 && rd[0]; i++) bus(1'b0, eptc_pkg::OFS_CTRL, 32'h0);
        chk(nm, 32'(rd[0]), 32'h0);
        wctl(32'h0);
    endtask
    task automatic seq(input logic [1:0] m, input logic [15:0] a,
                       input logic [7:0] d, input logic ok);
        wctl({27'h0, m, 3'h6});
        bus(1'b1, eptc_pkg::OFS_ARRAY, {8'h0, d, a});
        wctl({27'h0, m, 3'h7});
        bus(1'b0, eptc_pkg::OFS_CTRL, 32'h0);
        @(posedge hclk);
        chk("power", 32'(rd[0]), 32'(ok));
        chk("pump", 32'(pump_on), 32'(ok));
        if (ok) chk("cmd", 32'(acmd), 32'({a, d, m}));
        wait_done("auto_end");
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_basic();
        rdchk(eptc_pkg::OFS_DIVH, 32'h80, "divh_load");
        rdchk(eptc_pkg::OFS_DIVL, 32'h10, "divl_write");
        rdchk(8'h3C, 32'h0, "unmapped");
        wctl(32'h2);
        bus(1'b1, eptc_pkg::OFS_DIVL, 32'h55);
        rdchk(eptc_pkg::OFS_DIVL, 32'h10, "divl_latched");
        wctl(32'h1);
        rdchk(eptc_pkg::OFS_CTRL, 32'h0, "power_no_latch");
        seq(2'h0, 16'h0700, 8'h00, 1'b0);
        bus(1'b1, eptc_pkg::OFS_ACR, 32'h0);
        rdchk(eptc_pkg::OFS_ACR, 32'h10, "acr_spare_clr");
        bus(1'b1, eptc_pkg::OFS_ACR, 32'hAF);
        rdchk(eptc_pkg::OFS_ACR, 32'hB0, "acr_spare_set");
    endtask
    task automatic t_latch_stop();
        wctl(32'h2);
        bus(1'b1, eptc_pkg::OFS_ARRAY, 32'h0810);
        wctl(32'h3);
        wctl(32'h0);
        rdchk(eptc_pkg::OFS_CTRL, 32'h2, "latch_kept");
        repeat (3) @(posedge hclk);
        chk("pump_off", 32'(pump_on), 32'h0);
        wctl(32'h0);
        rdchk(eptc_pkg::OFS_CTRL, 32'h0, "latch_clr");
        for (int m = 0; m < 4; m++) seq(2'(m), 16'h0900, 8'h00, 1'b1);
        wctl(32'h6);
        bus(1'b1, eptc_pkg::OFS_ARRAY, 32'h0820);
        wctl(32'h7);
        stop_mode <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("pump_stop", 32'(pump_on), 32'h0);
        stop_mode <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("pump_restart", 32'(pump_on), 32'h1);
        bus(1'b0, eptc_pkg::OFS_STAT, 32'h0);
        chk("restarted", rd & 32'h5, 32'h5);
        bus(1'b0, eptc_pkg::OFS_CTRL, 32'h0);
        wait_done("stop_end");
    endtask
    // clock enable low must hold a running sequence where it stands
    task automatic t_freeze();
        wctl(32'h6);
        bus(1'b1, eptc_pkg::OFS_ARRAY, 32'h0830);
        wctl(32'h7);
        repeat (3) @(posedge hclk);
        ce <= 1'b0;
        repeat (300) @(posedge hclk);
        chk("pump_frozen", 32'(pump_on), 32'h1);
        ce <= 1'b1;
        bus(1'b0, eptc_pkg::OFS_CTRL, 32'h0);
        wait_done("freeze_end");
    endtask
    task automatic t_protect();
        seq(2'h1, eptc_pkg::NVA_ACR, 8'h00, 1'b1);
        rdchk(eptc_pkg::OFS_ACR_NV, 32'hFF, "nv_erase");
        seq(2'h0, eptc_pkg::NVA_ACR, 8'hF2, 1'b1);
        reboot(32'hF2);
        seq(2'h0, 16'h0800, 8'h00, 1'b1);
        seq(2'h0, 16'h0880, 8'h00, 1'b0);
        seq(2'h2, 16'h097F, 8'h00, 1'b1);
        seq(2'h0, 16'h09FF, 8'h00, 1'b1);
        seq(2'h0, eptc_pkg::NVA_ACR, 8'hE0, 1'b1);
        reboot(32'hE0);
        seq(2'h1, 16'h08EF, 8'h00, 1'b1);
        seq(2'h0, eptc_pkg::SEC_LO, 8'h00, 1'b0);
        seq(2'h1, eptc_pkg::SEC_HI, 8'h00, 1'b0);
        seq(2'h2, 16'h0800, 8'h00, 1'b0);
        seq(2'h3, 16'h0900, 8'h00, 1'b0);
        seq(2'h1, eptc_pkg::NVA_ACR, 8'h00, 1'b1);
        reboot(32'hEF);
    endtask
    task automatic t_div_lock();
        seq(2'h0, eptc_pkg::NVA_DIVH, 8'h00, 1'b1);
        reboot(32'hEF);
        rdchk(eptc_pkg::OFS_DIVH, 32'h00, "divh_locked");
        rdchk(eptc_pkg::OFS_DIVL, 32'hAC, "divl_frozen");
        bus(1'b1, eptc_pkg::OFS_DIVH, 32'h80);
        rdchk(eptc_pkg::OFS_DIVH, 32'h00, "lock_frozen");
        seq(2'h1, eptc_pkg::NVA_DIVH, 8'h00, 1'b0);
    endtask
    initial begin
        @(posedge hclk);
        por_n <= 1'b1;
        reboot(32'hF0);
        t_basic();
        t_latch_stop();
        t_freeze();
        t_protect();
        t_div_lock();
        complete_run();
    end
endmodule
`default_nettype wire
